// [logic/slcc_pkg.sv]
// Purpose: shared constants for the synthesizer 2 loop and calibration register bank
// Assumes: 8-bit register offsets and 8-bit data; ref_clk is the always-on clock
// Notes:   wait times are kept in ns and turned into ref_clk cycle counts here
package slcc_pkg;

  // ==========================================================================
  // register offsets
  localparam logic [7:0] SLCC_OFS_LOOP_FILTER = 8'h84;
  localparam logic [7:0] SLCC_OFS_CAL_WAIT    = 8'h85;
  localparam logic [7:0] SLCC_OFS_BANDWIDTH   = 8'h86;
  localparam logic [7:0] SLCC_OFS_PROG_COUNT  = 8'h88;

  // ==========================================================================
  // field positions and widths
  localparam int unsigned SLCC_LF_LSB   = 0;
  localparam int unsigned SLCC_LF_W     = 3;
  localparam int unsigned SLCC_VCO_LSB  = 0;
  localparam int unsigned SLCC_CL_LSB   = 2;
  localparam int unsigned SLCC_WAIT_W   = 2;
  localparam int unsigned SLCC_BW_BIT   = 0;
  localparam int unsigned SLCC_CNT_W    = 8;

  // ==========================================================================
  // field codes and reset values
  localparam logic [2:0] SLCC_LF_SECOND_ORDER = 3'h3;
  localparam logic [2:0] SLCC_LF_THIRD_ORDER  = 3'h7;
  localparam logic [2:0] SLCC_LF_RESET        = 3'h3;
  localparam logic [1:0] SLCC_CL_RESET        = 2'h0;
  localparam logic [1:0] SLCC_VCO_RESET       = 2'h1;
  localparam logic       SLCC_BW_RESET        = 1'b0;
  localparam logic [7:0] SLCC_CNT_RESET       = 8'h00;
  localparam logic [7:0] SLCC_CNT_MAX         = 8'hff;

  // ==========================================================================
  // timing: clock period and wait times in ns
  localparam int unsigned SLCC_CLK_NS   = 100;
  localparam int unsigned SLCC_CL0_NS   = 30000;
  localparam int unsigned SLCC_CL1_NS   = 300000;
  localparam int unsigned SLCC_CL2_NS   = 30000000;
  localparam int unsigned SLCC_CL3_NS   = 300000000;
  localparam int unsigned SLCC_VCO0_NS  = 20000;
  localparam int unsigned SLCC_VCO1_NS  = 400000;
  localparam int unsigned SLCC_VCO2_NS  = 8000000;
  localparam int unsigned SLCC_VCO3_NS  = 200000000;

  // least waits, rounded up to whole cycles
  localparam int unsigned SLCC_CL0_CYC  = (SLCC_CL0_NS + SLCC_CLK_NS - 1) / SLCC_CLK_NS;
  localparam int unsigned SLCC_CL1_CYC  = (SLCC_CL1_NS + SLCC_CLK_NS - 1) / SLCC_CLK_NS;
  localparam int unsigned SLCC_CL2_CYC  = (SLCC_CL2_NS + SLCC_CLK_NS - 1) / SLCC_CLK_NS;
  localparam int unsigned SLCC_CL3_CYC  = (SLCC_CL3_NS + SLCC_CLK_NS - 1) / SLCC_CLK_NS;
  localparam int unsigned SLCC_VCO0_CYC = (SLCC_VCO0_NS + SLCC_CLK_NS - 1) / SLCC_CLK_NS;
  localparam int unsigned SLCC_VCO1_CYC = (SLCC_VCO1_NS + SLCC_CLK_NS - 1) / SLCC_CLK_NS;
  localparam int unsigned SLCC_VCO2_CYC = (SLCC_VCO2_NS + SLCC_CLK_NS - 1) / SLCC_CLK_NS;
  localparam int unsigned SLCC_VCO3_CYC = (SLCC_VCO3_NS + SLCC_CLK_NS - 1) / SLCC_CLK_NS;

  // wait timer width, big enough for the longest wait
  localparam int unsigned SLCC_TMR_W    = 22;

  // wait timer states
  typedef enum logic [1:0] {
    SLCC_TMR_IDLE    = 2'b00,
    SLCC_TMR_RUN     = 2'b01,
    SLCC_TMR_SETTLED = 2'b10
  } slcc_tmr_state_e;

endpackage

// [logic/slcc_wait_timer.sv]
// Purpose: settle wait timer, counts ref_clk periods for a coded wait time
// Assumes: start is a one-cycle pulse; code is sampled at start
// Notes:   a new start restarts the wait and drops settled
`timescale 1ns/10ps
`default_nettype none
module slcc_wait_timer #(
  parameter int unsigned CYC0 = 300,
  parameter int unsigned CYC1 = 3000,
  parameter int unsigned CYC2 = 300000,
  parameter int unsigned CYC3 = 3000000
) (
  // clock and reset
  input  wire logic                          ref_clk,
  input  wire logic                          arst_n,
  // control
  input  wire logic                          start,
  input  wire logic [slcc_pkg::SLCC_WAIT_W-1:0] code,
  // status
  output var  logic                          busy,
  output var  logic                          settled
);
  import slcc_pkg::*;

  slcc_tmr_state_e         state;
  slcc_tmr_state_e         next_state;
  logic [SLCC_TMR_W-1:0]   cnt;
  logic [SLCC_TMR_W-1:0]   next_cnt;

  // cycle count for a wait code, less one for the terminal cycle
  function automatic logic [SLCC_TMR_W-1:0] wait_len(input logic [SLCC_WAIT_W-1:0] c);
    case (c)
      2'h0:    wait_len = SLCC_TMR_W'(CYC0 - 1);
      2'h1:    wait_len = SLCC_TMR_W'(CYC1 - 1);
      2'h2:    wait_len = SLCC_TMR_W'(CYC2 - 1);
      default: wait_len = SLCC_TMR_W'(CYC3 - 1);
    endcase
  endfunction

  // next state and count
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      SLCC_TMR_IDLE, SLCC_TMR_SETTLED: begin
        if (start) begin
          next_state = SLCC_TMR_RUN;
          next_cnt   = wait_len(code);
        end
      end
      SLCC_TMR_RUN: begin
        if (start) begin
          next_cnt = wait_len(code);
        end else if (cnt == '0) begin
          next_state = SLCC_TMR_SETTLED;
        end else begin
          next_cnt = cnt - 1'b1;
        end
      end
      default: begin
        next_state = SLCC_TMR_IDLE;
        next_cnt   = '0;
      end
    endcase
  end

  // register state
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= SLCC_TMR_IDLE;
      cnt   <= '0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign busy    = (state == SLCC_TMR_RUN);
  assign settled = (state == SLCC_TMR_SETTLED);

endmodule // slcc_wait_timer
`default_nettype wire

// [logic/slcc_prog_counter.sv]
// Purpose: saturating erase/program cycle counter with reload from storage
// Assumes: load and prog_done are one-cycle pulses
// Notes:   a load in the same cycle as prog_done wins
`timescale 1ns/10ps
`default_nettype none
module slcc_prog_counter (
  // clock and reset
  input  wire logic                           ref_clk,
  input  wire logic                           arst_n,
  // events
  input  wire logic                           load,
  input  wire logic [slcc_pkg::SLCC_CNT_W-1:0] load_value,
  input  wire logic                           prog_done,
  // count and store request
  output var  logic [slcc_pkg::SLCC_CNT_W-1:0] count,
  output var  logic                           store,
  output var  logic [slcc_pkg::SLCC_CNT_W-1:0] store_value
);
  import slcc_pkg::*;

  logic [SLCC_CNT_W-1:0] next_count;
  logic                  next_store;
  logic [SLCC_CNT_W-1:0] bumped;

  // saturating increment; a reload wins and no store is requested
  always_comb begin
    bumped     = (count == SLCC_CNT_MAX) ? count : count + 1'b1;
    next_count = count;
    next_store = 1'b0;
    if (load) begin
      next_count = load_value;
    end else if (prog_done) begin
      next_count = bumped;
      next_store = 1'b1;
    end
  end

  // register count and store pulse
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      count       <= SLCC_CNT_RESET;
      store       <= 1'b0;
      store_value <= SLCC_CNT_RESET;
    end else begin
      count       <= next_count;
      store       <= next_store;
      store_value <= next_count;
    end
  end

endmodule // slcc_prog_counter
`default_nettype wire

// [logic/slcc_regs.sv]
// Purpose: synthesizer 2 loop filter, calibration wait and bandwidth registers
//          plus the read-only erase/program cycle counter
// Assumes: register port comes from the serial configuration slave,
//          ref_clk is the always-on clock, all inputs synchronous to it
// Notes:   read data is registered one cycle after rd_en
//
// Function
// - code 3 selects second-order loop filter
// - code 7 selects third-order loop filter
// - filter field read/write, resets to 3
// - closed-loop wait codes map to four times
// - closed-loop settle delay follows wait field
// - vco wait codes map times, reset 1
// - narrow bit set gives 200 Hz bandwidth
// - narrow bit clear keeps normal bandwidth
// - counter increments after each program cycle
// - counter saturates at 255
// - counter reloads after reset, commit, program
// - count persists in storage, zero before load
// - waits counted in always-on clock periods
// - program start bit begins program cycle
`timescale 1ns/10ps
`default_nettype none
module slcc_regs #(
  parameter int unsigned CL_WAIT2_CYC  = slcc_pkg::SLCC_CL2_CYC,
  parameter int unsigned CL_WAIT3_CYC  = slcc_pkg::SLCC_CL3_CYC,
  parameter int unsigned VCO_WAIT2_CYC = slcc_pkg::SLCC_VCO2_CYC,
  parameter int unsigned VCO_WAIT3_CYC = slcc_pkg::SLCC_VCO3_CYC
) (
  // clock and reset
  input  wire logic                            ref_clk,
  input  wire logic                            arst_n,
  // register port
  input  wire logic [7:0]                      reg_addr,
  input  wire logic                            reg_wr_en,
  input  wire logic [7:0]                      reg_wr_data,
  input  wire logic                            reg_rd_en,
  output var  logic [7:0]                      reg_rd_data,
  // stored image load (reset-time load and commit)
  input  wire logic                            image_load,
  input  wire logic [slcc_pkg::SLCC_LF_W-1:0]  image_loop_filter,
  input  wire logic [slcc_pkg::SLCC_WAIT_W-1:0] image_cl_wait,
  input  wire logic [slcc_pkg::SLCC_WAIT_W-1:0] image_vco_wait,
  input  wire logic                            image_narrow_bw,
  input  wire logic [slcc_pkg::SLCC_CNT_W-1:0] image_count,
  // program cycle events
  input  wire logic                            program_start,
  input  wire logic                            program_done,
  output var  logic                            program_busy,
  output var  logic                            count_store,
  output var  logic [slcc_pkg::SLCC_CNT_W-1:0] count_store_value,
  // calibration sequencing
  input  wire logic                            vco_cal_start,
  input  wire logic                            closed_loop_start,
  output var  logic                            vco_settled,
  output var  logic                            loop_settled,
  // analog controls
  output var  logic [slcc_pkg::SLCC_LF_W-1:0]  loop_filter_order_sel,
  output var  logic                            second_order_en,
  output var  logic                            third_order_en,
  output var  logic                            filter_code_reserved,
  output var  logic                            narrow_loop_bw
);
  import slcc_pkg::*;

  // ==========================================================================
  // control fields

  logic [SLCC_LF_W-1:0]   lf_order;
  logic [SLCC_LF_W-1:0]   next_lf_order;
  logic [SLCC_WAIT_W-1:0] closed_loop_wait_code;
  logic [SLCC_WAIT_W-1:0] next_closed_loop_wait_code;
  logic [SLCC_WAIT_W-1:0] vco_settle_wait_code;
  logic [SLCC_WAIT_W-1:0] next_vco_settle_wait_code;
  logic                   narrow_bw;
  logic                   next_narrow_bw;
  logic                   busy;
  logic                   next_busy;
  logic [7:0]             rd_data;
  logic [7:0]             next_rd_data;
  logic [SLCC_CNT_W-1:0]  program_cycle_count;
  logic                   cl_busy;
  logic                   vco_busy;
  logic                   prog_event;

  // address decode, used by the write and read paths
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // next values of the writable fields; a stored image load wins over a write
  always_comb begin
    next_lf_order              = lf_order;
    next_closed_loop_wait_code = closed_loop_wait_code;
    next_vco_settle_wait_code  = vco_settle_wait_code;
    next_narrow_bw             = narrow_bw;
    if (image_load) begin
      next_lf_order              = image_loop_filter;
      next_closed_loop_wait_code = image_cl_wait;
      next_vco_settle_wait_code  = image_vco_wait;
      next_narrow_bw             = image_narrow_bw;
    end else if (reg_wr_en) begin
      // only defined field bits are taken, the rest dropped
      if (hit(reg_addr, SLCC_OFS_LOOP_FILTER)) begin
        next_lf_order = reg_wr_data[SLCC_LF_LSB +: SLCC_LF_W];
      end
      if (hit(reg_addr, SLCC_OFS_CAL_WAIT)) begin
        next_closed_loop_wait_code = reg_wr_data[SLCC_CL_LSB +: SLCC_WAIT_W];
        next_vco_settle_wait_code  = reg_wr_data[SLCC_VCO_LSB +: SLCC_WAIT_W];
      end
      if (hit(reg_addr, SLCC_OFS_BANDWIDTH)) begin
        next_narrow_bw = reg_wr_data[SLCC_BW_BIT];
      end
    end
  end

  // register the writable fields
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      lf_order              <= SLCC_LF_RESET;
      closed_loop_wait_code <= SLCC_CL_RESET;
      vco_settle_wait_code  <= SLCC_VCO_RESET;
      narrow_bw             <= SLCC_BW_RESET;
    end else begin
      lf_order              <= next_lf_order;
      closed_loop_wait_code <= next_closed_loop_wait_code;
      vco_settle_wait_code  <= next_vco_settle_wait_code;
      narrow_bw             <= next_narrow_bw;
    end
  end

  // ==========================================================================
  // analog control decode

  // filter order outputs; reserved codes enable neither order
  always_comb begin
    loop_filter_order_sel = lf_order;
    second_order_en       = (lf_order == SLCC_LF_SECOND_ORDER);
    third_order_en        = (lf_order == SLCC_LF_THIRD_ORDER);
    filter_code_reserved  = !(second_order_en || third_order_en);
    narrow_loop_bw        = narrow_bw;
  end

  // ==========================================================================
  // program cycle tracking

  // busy from program start to program done
  always_comb begin
    next_busy = busy;
    if (program_start) begin
      next_busy = 1'b1;
    end else if (program_done) begin
      next_busy = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy <= 1'b0;
    end else begin
      busy <= next_busy;
    end
  end

  assign program_busy = busy;
  assign prog_event   = busy && program_done;

  // saturating counter, reloaded from the stored image
  slcc_prog_counter u_prog_counter (
    .ref_clk     (ref_clk),
    .arst_n      (arst_n),
    .load        (image_load),
    .load_value  (image_count),
    .prog_done   (prog_event),
    .count       (program_cycle_count),
    .store       (count_store),
    .store_value (count_store_value)
  );

  // ==========================================================================
  // settle wait timers on the always-on clock

  // vco stabilization wait
  slcc_wait_timer #(
    .CYC0 (SLCC_VCO0_CYC),
    .CYC1 (SLCC_VCO1_CYC),
    .CYC2 (VCO_WAIT2_CYC),
    .CYC3 (VCO_WAIT3_CYC)
  ) u_vco_timer (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .start   (vco_cal_start),
    .code    (vco_settle_wait_code),
    .busy    (vco_busy),
    .settled (vco_settled)
  );

  // closed-loop stabilization wait
  slcc_wait_timer #(
    .CYC0 (SLCC_CL0_CYC),
    .CYC1 (SLCC_CL1_CYC),
    .CYC2 (CL_WAIT2_CYC),
    .CYC3 (CL_WAIT3_CYC)
  ) u_cl_timer (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .start   (closed_loop_start),
    .code    (closed_loop_wait_code),
    .busy    (cl_busy),
    .settled (loop_settled)
  );

  // ==========================================================================
  // read path

  // registered read data, reserved bits and unmapped offsets read zero
  always_comb begin
    next_rd_data = rd_data;
    if (reg_rd_en) begin
      next_rd_data = 8'h00;
      if (hit(reg_addr, SLCC_OFS_LOOP_FILTER)) begin
        next_rd_data[SLCC_LF_LSB +: SLCC_LF_W] = lf_order;
      end
      if (hit(reg_addr, SLCC_OFS_CAL_WAIT)) begin
        next_rd_data[SLCC_CL_LSB +: SLCC_WAIT_W]  = closed_loop_wait_code;
        next_rd_data[SLCC_VCO_LSB +: SLCC_WAIT_W] = vco_settle_wait_code;
      end
      if (hit(reg_addr, SLCC_OFS_BANDWIDTH)) begin
        next_rd_data[SLCC_BW_BIT] = narrow_bw;
      end
      if (hit(reg_addr, SLCC_OFS_PROG_COUNT)) begin
        next_rd_data = program_cycle_count;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  assign reg_rd_data = rd_data;

endmodule // slcc_regs
`default_nettype wire

// [tb/slcc_regs_properties.sv]
// Purpose: concurrent checks on the loop and calibration register bank ports
// Assumes: one ref_clk domain, arst_n active low
// Notes:   bound to slcc_regs from the bench top file
`timescale 1ns/10ps
`default_nettype none
module slcc_regs_properties (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       arst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic       reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic       reg_rd_en,
  input wire logic [7:0] reg_rd_data,
  // events
  input wire logic       image_load,
  input wire logic       program_start,
  input wire logic       program_done,
  input wire logic       program_busy,
  input wire logic       count_store,
  input wire logic       vco_cal_start,
  input wire logic       closed_loop_start,
  input wire logic       vco_settled,
  input wire logic       loop_settled,
  // analog controls
  input wire logic [2:0] loop_filter_order_sel,
  input wire logic       second_order_en,
  input wire logic       third_order_en,
  input wire logic       filter_code_reserved,
  input wire logic       narrow_loop_bw
);
  // ==========================================================================
  // port relations
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_second_order_dec: assert property (second_order_en == (loop_filter_order_sel == 3'h3))
    else $error("second order enable does not follow code 3");
  a_third_order_dec: assert property (third_order_en == (loop_filter_order_sel == 3'h7))
    else $error("third order enable does not follow code 7");
  a_filter_write_lands: assert property (reg_wr_en && !image_load && reg_addr == 8'h84
    |=> loop_filter_order_sel == $past(reg_wr_data[2:0])) else $error("filter write lost");
  a_store_after_done: assert property (program_done && program_busy && !image_load
    && !program_start |=> count_store) else $error("no store after program cycle");
  a_busy_after_start: assert property (program_start |=> program_busy)
    else $error("busy not raised after program start");
  a_unmapped_read_zero: assert property (reg_rd_en
    && !(reg_addr inside {8'h84, 8'h85, 8'h86, 8'h88}) |=> reg_rd_data == 8'h00)
    else $error("unmapped read not zero");
  a_loop_wait_min: assert property (closed_loop_start |=> !loop_settled [*8])
    else $error("loop settled too early");
  a_vco_wait_min: assert property (vco_cal_start |=> !vco_settled [*8])
    else $error("vco settled too early");
  a_loop_settle_hold: assert property (loop_settled && !closed_loop_start |=> loop_settled)
    else $error("loop settled dropped without start");
endmodule // slcc_regs_properties
`default_nettype wire

// [tb/slcc_regs_tb.sv]
// Purpose: self-checking bench for the loop and calibration register bank
// Assumes: short parameter values stand in for the long waits
// Notes:   inputs change on the falling edge of ref_clk
`timescale 1ns/10ps
`default_nettype none
module slcc_regs_tb;
  import slcc_pkg::*;
  // ==========================================================================
  // clock, reset and ports
  localparam int unsigned CL2 = 20, CL3 = 40, V2 = 30, V3 = 50;
  logic       ref_clk = 1'b0, arst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wr_data = 8'h00, reg_rd_data, count_store_value;
  logic       image_load = 1'b0, image_narrow_bw = 1'b0;
  logic [2:0] image_loop_filter = 3'h0, loop_filter_order_sel;
  logic [1:0] image_cl_wait = 2'h0, image_vco_wait = 2'h0;
  logic [7:0] image_count = 8'h00;
  logic       program_start = 1'b0, program_done = 1'b0, program_busy, count_store;
  logic       vco_cal_start = 1'b0, closed_loop_start = 1'b0, vco_settled, loop_settled;
  logic       second_order_en, third_order_en, filter_code_reserved, narrow_loop_bw;
  int         bad_count = 0, n_compared = 0, n;
  // register rows: offset, write data, read back
  logic [23:0] rows [8] = '{24'h84ff07, 24'h840303, 24'h85ff0f, 24'h86ff01,
                            24'h860000, 24'h88ff00, 24'h87ff00, 24'h840505};
  int wexp [8] = '{SLCC_VCO0_CYC + 1, SLCC_VCO1_CYC + 1, V2 + 1, V3 + 1,
                   SLCC_CL0_CYC + 1, SLCC_CL1_CYC + 1, CL2 + 1, CL3 + 1};

  // clock generator
  always #50 ref_clk = ~ref_clk;

  slcc_regs #(.CL_WAIT2_CYC(CL2), .CL_WAIT3_CYC(CL3), .VCO_WAIT2_CYC(V2),
              .VCO_WAIT3_CYC(V3)) DUT (.*);

  // ==========================================================================
  // tasks
  task automatic check(input string what, input logic [7:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(negedge ref_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    reg_wr_en = 1'b0;
  endtask
  task automatic rdck(input logic [7:0] a, exp);
    @(negedge ref_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge ref_clk);
    reg_rd_en = 1'b0;
    check("reg_rd_data", reg_rd_data, exp);
  endtask
  // one full program cycle, count expected afterwards
  task automatic prog(input logic [7:0] exp);
    @(negedge ref_clk);
    program_start = 1'b1;
    @(negedge ref_clk);
    program_start = 1'b0;
    check("program_busy", program_busy, 8'h01);
    program_done = 1'b1;
    @(negedge ref_clk);
    program_done = 1'b0;
    check("count_store", count_store, 8'h01);
    check("count_store_value", count_store_value, exp);
    check("program_busy", program_busy, 8'h00);
    rdck(SLCC_OFS_PROG_COUNT, exp);
  endtask
  // coded wait, cycles from start edge to settled
  task automatic wt(input logic sel, input logic [1:0] c, input int exp);
    wr(SLCC_OFS_CAL_WAIT, {4'h0, c, c});
    @(negedge ref_clk);
    if (sel) closed_loop_start = 1'b1;
    else vco_cal_start = 1'b1;
    @(negedge ref_clk);
    closed_loop_start = 1'b0;
    vco_cal_start = 1'b0;
    n = 1;
    while (((sel ? loop_settled : vco_settled) !== 1'b1) && n < 9000) begin
      @(negedge ref_clk);
      n++;
    end
    n_compared++;
    if (n != exp) begin
      bad_count++;
      $display("mismatch settle_cycles expected %0d seen %0d", exp, n);
    end
    if (n >= 9000) summarize();
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (2) @(negedge ref_clk);
    arst_n = 1'b1;
    check("second_order_en", second_order_en, 8'h01);
    check("narrow_loop_bw", narrow_loop_bw, 8'h00);
    rdck(SLCC_OFS_LOOP_FILTER, 8'h03);
    rdck(SLCC_OFS_CAL_WAIT, 8'h01);
    rdck(SLCC_OFS_BANDWIDTH, 8'h00);
    rdck(SLCC_OFS_PROG_COUNT, 8'h00);
    $display("done reset values");
    for (int i = 0; i < 8; i++) begin
      wr(rows[i][23:16], rows[i][15:8]);
      rdck(rows[i][23:16], rows[i][7:0]);
    end
    $display("done register rows");
    for (int i = 0; i < 8; i++) begin
      wr(SLCC_OFS_LOOP_FILTER, 8'(i));
      check("loop_filter_order_sel", loop_filter_order_sel, 8'(i));
      check("second_order_en", second_order_en, 8'(i == 3));
      check("third_order_en", third_order_en, 8'(i == 7));
      check("filter_code_reserved", filter_code_reserved, 8'(i != 3 && i != 7));
    end
    wr(SLCC_OFS_BANDWIDTH, 8'h01); // narrow bit set with third-order filter
    check("narrow_loop_bw", narrow_loop_bw, 8'h01);
    $display("done filter codes and bandwidth");
    prog(8'h01);
    @(negedge ref_clk);
    program_done = 1'b1;
    @(negedge ref_clk);
    program_done = 1'b0;
    rdck(SLCC_OFS_PROG_COUNT, 8'h01);
    // image load beats a write in the same cycle
    @(negedge ref_clk);
    image_loop_filter = 3'h7;
    image_cl_wait = 2'h2;
    image_vco_wait = 2'h3;
    image_narrow_bw = 1'b1;
    image_count = 8'hfe;
    image_load = 1'b1;
    reg_addr = SLCC_OFS_LOOP_FILTER;
    reg_wr_data = 8'h03;
    reg_wr_en = 1'b1;
    @(negedge ref_clk);
    image_load = 1'b0;
    reg_wr_en = 1'b0;
    check("third_order_en", third_order_en, 8'h01);
    rdck(SLCC_OFS_LOOP_FILTER, 8'h07);
    rdck(SLCC_OFS_CAL_WAIT, 8'h0b);
    rdck(SLCC_OFS_PROG_COUNT, 8'hfe);
    prog(8'hff);
    prog(8'hff);
    @(negedge ref_clk);
    image_count = 8'h10;
    image_load = 1'b1;
    @(negedge ref_clk);
    image_load = 1'b0;
    rdck(SLCC_OFS_PROG_COUNT, 8'h10);
    prog(8'h11);
    $display("done program count");
    for (int i = 0; i < 8; i++) wt(i >= 4, 2'(i), wexp[i]);
    // clock generator mode: closed-loop code 1, vco code 1
    wr(SLCC_OFS_CAL_WAIT, 8'h05);
    rdck(SLCC_OFS_CAL_WAIT, 8'h05);
    $display("done wait timers");
    // reset in mid-run
    @(negedge ref_clk);
    arst_n = 1'b0;
    #1;
    check("second_order_en", second_order_en, 8'h01);
    check("loop_settled", loop_settled, 8'h00);
    @(negedge ref_clk);
    arst_n = 1'b1;
    rdck(SLCC_OFS_LOOP_FILTER, 8'h03);
    rdck(SLCC_OFS_PROG_COUNT, 8'h00);
    $display("done second reset");
    summarize();
  end
endmodule // slcc_regs_tb

bind slcc_regs slcc_regs_properties u_props (.*);
`default_nettype wire
